//--- hdl/lcdcd_decoder.sv
// command decoder and display ram access for a dot-matrix lcd controller
`timescale 1ns/1ps
`include "lcdcd_cfg.svh"
// Contract
// - two nibble commands form column pointer
// - ram writes and non-rmw reads advance column by one
// - column stops at 83h, page untouched
// - status adc flag one means forward mapping
// - status off flag is one when display off
// - status reset flag high during reset
// - data write stores byte, then advances column
// - data read returns byte, advances unless rmw
// - first read after column set is dummy
// - serial mode has no ram read path
// - segment direction command bit zero selects mapping
// - invert command swaps lit polarity, ram kept
// - all-on lights every dot while display on, beats invert
// - bias bit picks 1/9 or 1/7, needs follower
// - rmw reads hold column, writes still advance
// - rmw saves column, end command restores it
// - transfers classified by reg_select and direction
// - reset clears column, forward, 1/9, off, no rmw

module lcdcd_decoder
    import lcdcd_pkg::*;
#(
    parameter int COLS        = `LCDCD_COL_COUNT,   // columns per page
    parameter int PAGES       = `LCDCD_PAGE_COUNT,  // pages of display ram
    parameter int RESET_BUSY  = `LCDCD_RESET_BUSY   // cycles the reset flag stays up
) (
    input  wire logic       core_clk,         // block clock, 200 MHz
    input  wire logic       rst_b,            // asynchronous reset, active low
    input  wire logic       clk_en,           // freezes all state while low
    input  wire lcdcd_req_t host_req,         // one host transfer per strobe
    input  wire logic       serial_mode,      // serial interface selected
    input  wire logic [3:0] page_addr,        // current page from page logic
    input  wire logic       vf_running,       // voltage follower stage running
    input  wire logic [7:0] disp_seg,         // segment being scanned
    input  wire logic [3:0] disp_page,        // page being scanned
    output logic      [7:0] rd_data,          // read answer byte
    output logic            rd_valid,         // one-cycle pulse with rd_data
    output logic      [7:0] column,           // current column pointer
    output logic            seg_reverse,      // reversed segment mapping
    output logic            display_on,       // display enabled
    output logic            invert_on,        // ram zero lights a dot
    output logic            all_on,           // every dot forced on
    output logic            bias_seventh,     // applied bias, 1 = 1/7
    output logic            rmw_active,       // read-modify-write mode
    output logic            reset_busy,       // reset in progress
    output logic      [7:0] segment_output    // dots for disp_seg on disp_page
);

    // ----------------------------------------------------------------
    // local widths and helpers
    // ----------------------------------------------------------------
    localparam int IDX_W = $clog2(COLS * PAGES);
    localparam int BSY_W = $clog2(RESET_BUSY + 1);

    // flat ram index for a page and column
    function automatic logic [IDX_W-1:0] ram_index(input logic [3:0] pg,
                                                   input logic [7:0] col);
        ram_index = IDX_W'(pg * COLS + col);
    endfunction

    // true when page and column fall inside the ram
    function automatic logic in_range(input logic [3:0] pg, input logic [7:0] col);
        in_range = (int'(pg) < PAGES) && (int'(col) < COLS);
    endfunction

    // opcode decode, used by every command process
    function automatic lcdcd_op_t classify(input logic [7:0] b);
        if ((b & `LCDCD_MASK_NIB) == `LCDCD_OP_COL_HI) begin
            classify = LCDCD_OP_COL_HI;
        end else if ((b & `LCDCD_MASK_NIB) == `LCDCD_OP_COL_LO) begin
            classify = LCDCD_OP_COL_LO;
        end else if ((b & `LCDCD_MASK_BIT) == `LCDCD_OP_SEG_DIR) begin
            classify = LCDCD_OP_SEG_DIR;
        end else if ((b & `LCDCD_MASK_BIT) == `LCDCD_OP_BIAS) begin
            classify = LCDCD_OP_BIAS;
        end else if ((b & `LCDCD_MASK_BIT) == `LCDCD_OP_ALL_ON) begin
            classify = LCDCD_OP_ALL_ON;
        end else if ((b & `LCDCD_MASK_BIT) == `LCDCD_OP_INVERT) begin
            classify = LCDCD_OP_INVERT;
        end else if ((b & `LCDCD_MASK_BIT) == `LCDCD_OP_DISP) begin
            classify = LCDCD_OP_DISP;
        end else if ((b & `LCDCD_MASK_ALL) == `LCDCD_OP_RMW) begin
            classify = LCDCD_OP_RMW;
        end else if ((b & `LCDCD_MASK_ALL) == `LCDCD_OP_END) begin
            classify = LCDCD_OP_END;
        end else begin
            classify = LCDCD_OP_NONE;                                 // unknown: ignored
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]       ram [COLS*PAGES];   // display ram, flip-flops
    logic [7:0]       column_reg;         // column pointer
    logic [7:0]       saved_col_reg;      // column held across rmw
    logic [7:0]       latch_reg;          // read latch, one read behind
    logic [7:0]       rd_data_reg;        // read answer
    logic             rd_valid_reg;       // read answer strobe
    logic             seg_rev_reg;        // segment direction
    logic             disp_on_reg;        // display on
    logic             invert_reg;         // normal/inverted
    logic             all_on_reg;         // forced all on
    logic             bias_req_reg;       // requested bias
    logic             bias_app_reg;       // bias applied by follower
    logic             rmw_reg;            // rmw mode
    logic [BSY_W-1:0] busy_cnt_reg;       // reset flag countdown
    logic             busy_reg;           // reset flag, registered for the output
    logic [7:0]       seg_out_reg;        // scanned dots

    // ----------------------------------------------------------------
    // transfer classification
    // ----------------------------------------------------------------
    lcdcd_op_t  op;          // decoded command byte
    logic       cmd_wr;      // command write
    logic       sts_rd;      // status read
    logic       dat_wr;      // display data write
    logic       dat_rd;      // display data read
    logic [7:0] col_inc;     // column after one saturating step
    logic [7:0] status_byte; // assembled status

    // reg_select and direction together pick the transfer kind
    always_comb begin
        op     = classify(host_req.data);
        cmd_wr = host_req.valid && !host_req.reg_select && !host_req.read;
        sts_rd = host_req.valid && !host_req.reg_select && host_req.read;
        dat_wr = host_req.valid && host_req.reg_select && !host_req.read;
        // the serial port only moves bytes in, so reads never reach ram
        dat_rd = host_req.valid && host_req.reg_select && host_req.read
                 && !serial_mode;
    end

    // saturate at the last column; page logic is never told to move
    always_comb begin
        if (column_reg >= `LCDCD_COL_LAST) begin
            col_inc = `LCDCD_COL_LAST;
        end else begin
            col_inc = column_reg + 8'h01;
        end
    end

    // status byte: adc one means forward, off flag is the inverse of on
    always_comb begin
        status_byte                   = `LCDCD_RST_BYTE;
        status_byte[`LCDCD_STS_ADC]   = !seg_rev_reg;
        status_byte[`LCDCD_STS_OFF]   = !disp_on_reg;
        status_byte[`LCDCD_STS_RESET] = busy_reg;
    end

    // ----------------------------------------------------------------
    // reset-in-progress countdown after the reset pin releases
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_reg <= BSY_W'(RESET_BUSY);
        end else if (clk_en && busy_cnt_reg != '0) begin
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
        end
    end

    // flag in its own flop, tracking counter != 0, so the pin carries no compare logic
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b1;
        end else if (clk_en) begin
            busy_reg <= (busy_cnt_reg > BSY_W'(1));
        end
    end

    // ----------------------------------------------------------------
    // column pointer and rmw save/restore
    // ----------------------------------------------------------------
    // column set during rmw is the host's fault; it is still obeyed
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            column_reg    <= `LCDCD_RST_COL;
            saved_col_reg <= `LCDCD_RST_COL;
            rmw_reg       <= 1'b0;
        end else if (clk_en) begin
            if (cmd_wr) begin
                case (op)
                    LCDCD_OP_COL_HI: begin
                        column_reg[7:4] <= host_req.data[3:0];
                    end
                    LCDCD_OP_COL_LO: begin
                        column_reg[3:0] <= host_req.data[3:0];
                    end
                    LCDCD_OP_RMW: begin
                        saved_col_reg <= column_reg;
                        rmw_reg       <= 1'b1;
                    end
                    LCDCD_OP_END: begin
                        // end outside rmw leaves the pointer alone
                        if (rmw_reg) begin
                            column_reg <= saved_col_reg;
                        end
                        rmw_reg <= 1'b0;
                    end
                    default: begin
                        // other commands leave the pointer alone
                    end
                endcase
            end else if (dat_wr) begin
                column_reg <= col_inc;
            end else if (dat_rd && !rmw_reg) begin
                column_reg <= col_inc;
            end
            // reads in rmw mode hold the pointer
        end
    end

    // ----------------------------------------------------------------
    // display control settings
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            seg_rev_reg  <= 1'b0;
            disp_on_reg  <= 1'b0;
            invert_reg   <= 1'b0;
            all_on_reg   <= 1'b0;
            bias_req_reg <= 1'b0;
        end else if (clk_en && cmd_wr) begin
            case (op)
                LCDCD_OP_SEG_DIR: begin
                    seg_rev_reg <= host_req.data[0];
                end
                LCDCD_OP_DISP: begin
                    disp_on_reg <= host_req.data[0];
                end
                LCDCD_OP_INVERT: begin
                    invert_reg <= host_req.data[0];
                end
                LCDCD_OP_ALL_ON: begin
                    all_on_reg <= host_req.data[0];
                end
                LCDCD_OP_BIAS: begin
                    bias_req_reg <= host_req.data[0];
                end
                default: begin
                    // column and rmw commands handled above
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bias reaches the drive only while the follower runs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bias_app_reg <= 1'b0;
        end else if (clk_en && vf_running) begin
            bias_app_reg <= bias_req_reg;
        end
    end

    // ----------------------------------------------------------------
    // display ram write port; no reset, contents are data
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (clk_en && dat_wr && in_range(page_addr, column_reg)) begin
            ram[ram_index(page_addr, column_reg)] <= host_req.data;
        end
    end

    // ----------------------------------------------------------------
    // read latch: a data read returns the byte fetched by the previous
    // read, so the first read after a column set is the dummy one
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_reg <= `LCDCD_RST_BYTE;
        end else if (clk_en && dat_rd) begin
            if (in_range(page_addr, column_reg)) begin
                latch_reg <= ram[ram_index(page_addr, column_reg)];
            end else begin
                latch_reg <= `LCDCD_RST_BYTE;
            end
        end
    end

    // ----------------------------------------------------------------
    // read answer: status or latched data, one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_reg  <= `LCDCD_RST_BYTE;
            rd_valid_reg <= 1'b0;
        end else if (clk_en) begin
            rd_valid_reg <= sts_rd || dat_rd;
            if (sts_rd) begin
                rd_data_reg <= status_byte;
            end else if (dat_rd) begin
                rd_data_reg <= latch_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // scan path: segment to column mapping, then dot polarity
    // ----------------------------------------------------------------
    logic [7:0] scan_col;   // column that feeds disp_seg
    logic [7:0] scan_raw;   // ram byte at that column
    logic [7:0] scan_dots;  // lit dots after polarity and overrides

    always_comb begin
        if (seg_rev_reg) begin
            scan_col = `LCDCD_COL_LAST - disp_seg;
        end else begin
            scan_col = disp_seg;
        end
        if (in_range(disp_page, scan_col)) begin
            scan_raw = ram[ram_index(disp_page, scan_col)];
        end else begin
            scan_raw = `LCDCD_RST_BYTE;
        end
        // all-on outranks invert; an off display drives nothing
        if (!disp_on_reg) begin
            scan_dots = `LCDCD_RST_BYTE;
        end else if (all_on_reg) begin
            scan_dots = ~`LCDCD_RST_BYTE;
        end else if (invert_reg) begin
            scan_dots = ~scan_raw;
        end else begin
            scan_dots = scan_raw;
        end
    end

    // registered so the segment drivers see no decode glitches
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            seg_out_reg <= `LCDCD_RST_BYTE;
        end else if (clk_en) begin
            seg_out_reg <= scan_dots;
        end
    end

    // ----------------------------------------------------------------
    // outputs, each straight from a flip-flop
    // ----------------------------------------------------------------
    assign rd_data        = rd_data_reg;
    assign rd_valid       = rd_valid_reg;
    assign column         = column_reg;
    assign seg_reverse    = seg_rev_reg;
    assign display_on     = disp_on_reg;
    assign invert_on      = invert_reg;
    assign all_on         = all_on_reg;
    assign bias_seventh   = bias_app_reg;
    assign rmw_active     = rmw_reg;
    assign reset_busy     = busy_reg;
    assign segment_output = seg_out_reg;

endmodule

//--- shared/lcdcd_cfg.svh
// constants for the lcd ram access command decoder
`ifndef LCDCD_CFG_SVH
`define LCDCD_CFG_SVH

// ----------------------------------------------------------------
// command opcodes and match masks (reg_select low, write)
// ----------------------------------------------------------------
`define LCDCD_MASK_NIB     8'hF0
`define LCDCD_MASK_BIT     8'hFE
`define LCDCD_MASK_ALL     8'hFF
`define LCDCD_OP_COL_HI    8'h10
`define LCDCD_OP_COL_LO    8'h00
`define LCDCD_OP_SEG_DIR   8'hA0
`define LCDCD_OP_BIAS      8'hA2
`define LCDCD_OP_ALL_ON    8'hA4
`define LCDCD_OP_INVERT    8'hA6
`define LCDCD_OP_DISP      8'hAE
`define LCDCD_OP_RMW       8'hE0
`define LCDCD_OP_END       8'hEE

// ----------------------------------------------------------------
// geometry and column pointer limits
// ----------------------------------------------------------------
`define LCDCD_COL_LAST     8'h83
`define LCDCD_COL_COUNT    132
`define LCDCD_PAGE_COUNT   9

// ----------------------------------------------------------------
// status byte field positions
// ----------------------------------------------------------------
`define LCDCD_STS_ADC      6
`define LCDCD_STS_OFF      5
`define LCDCD_STS_RESET    4

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define LCDCD_RST_COL      8'h00
`define LCDCD_RST_BYTE     8'h00
`define LCDCD_RESET_BUSY   4

`endif

//--- shared/lcdcd_pkg.sv
// types shared by the lcd ram access command decoder
package lcdcd_pkg;

    // ----------------------------------------------------------------
    // one host bus transfer, valid for one cycle
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       valid;       // transfer strobe
        logic       reg_select;  // low: command/status, high: display data
        logic       read;        // high: read, low: write
        logic [7:0] data;        // write data
    } lcdcd_req_t;

    // ----------------------------------------------------------------
    // decoded command class, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [9:0] {
        LCDCD_OP_NONE    = 10'b00_0000_0001,
        LCDCD_OP_COL_HI  = 10'b00_0000_0010,
        LCDCD_OP_COL_LO  = 10'b00_0000_0100,
        LCDCD_OP_SEG_DIR = 10'b00_0000_1000,
        LCDCD_OP_BIAS    = 10'b00_0001_0000,
        LCDCD_OP_ALL_ON  = 10'b00_0010_0000,
        LCDCD_OP_INVERT  = 10'b00_0100_0000,
        LCDCD_OP_DISP    = 10'b00_1000_0000,
        LCDCD_OP_RMW     = 10'b01_0000_0000,
        LCDCD_OP_END     = 10'b10_0000_0000
    } lcdcd_op_t;

endpackage

//--- testbench/lcdcd_decoder_monitor.sv
// concurrent checks on the lcd decoder ports
`timescale 1ns/1ps
`include "lcdcd_cfg.svh"
module lcdcd_monitor
    import lcdcd_pkg::*;
#(
    parameter int COLS       = 132,  // columns per page
    parameter int PAGES      = 9,    // pages of ram
    parameter int RESET_BUSY = 4     // reset flag length
) (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       clk_en,
    input wire lcdcd_req_t host_req,
    input wire logic       serial_mode,
    input wire logic [3:0] page_addr,
    input wire logic       vf_running,
    input wire logic [7:0] disp_seg,
    input wire logic [3:0] disp_page,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic [7:0] column,
    input wire logic       seg_reverse,
    input wire logic       display_on,
    input wire logic       invert_on,
    input wire logic       all_on,
    input wire logic       bias_seventh,
    input wire logic       rmw_active,
    input wire logic       reset_busy,
    input wire logic [7:0] segment_output
);
    // ----------------------------------------------------------------
    // transfer decode
    // ----------------------------------------------------------------
    wire logic tk  = clk_en && host_req.valid;                        // taken transfer
    wire logic cmd = tk && !host_req.reg_select && !host_req.read;    // command write
    wire logic srd = tk && !host_req.reg_select && host_req.read;     // status read
    wire logic drd = tk && host_req.reg_select && host_req.read;      // data read
    wire logic dwr = tk && host_req.reg_select && !host_req.read;     // data write
    logic [7:0] saved_col;  // column seen at rmw entry
    // saturating increment, independent of the design's own helper
    function automatic logic [7:0] nxt(input logic [7:0] c);
        return (c >= `LCDCD_COL_LAST) ? `LCDCD_COL_LAST : c + 8'h01;
    endfunction
    // remember the column when rmw starts
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            saved_col <= 8'h00;
        end else if (cmd && host_req.data == 8'hE0) begin
            saved_col <= column;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    chk_status_byte: assert property (srd |=> rd_valid && rd_data == {1'b0,
        ~$past(seg_reverse), ~$past(display_on), $past(reset_busy), 4'h0}) else $error("status");
    chk_serial_silent: assert property (drd && serial_mode |=> !rd_valid)
        else $error("serial read answered");
    chk_read_adv: assert property (drd && !serial_mode && !rmw_active
        |=> rd_valid && column == nxt($past(column))) else $error("read advance");
    chk_write_adv: assert property (dwr |=> column == nxt($past(column)))
        else $error("write advance");
    chk_rmw_hold: assert property (drd && rmw_active |=> $stable(column))
        else $error("rmw read moved column");
    chk_col_high: assert property (cmd && host_req.data[7:4] == 4'h1
        |=> column == {$past(host_req.data[3:0]), $past(column[3:0])}) else $error("col hi");
    chk_seg_dir: assert property (cmd && host_req.data[7:1] == 7'h50
        |=> seg_reverse == $past(host_req.data[0])) else $error("seg dir");
    chk_rmw_end: assert property (cmd && host_req.data == 8'hEE && rmw_active
        |=> column == $past(saved_col) && !rmw_active) else $error("rmw end");
    chk_all_lit: assert property (clk_en && display_on && all_on
        |=> segment_output == 8'hFF) else $error("all on");
    chk_dark_off: assert property (clk_en && !display_on |=> segment_output == 8'h00)
        else $error("display off");
endmodule
bind lcdcd_decoder lcdcd_monitor #(.COLS(COLS), .PAGES(PAGES), .RESET_BUSY(RESET_BUSY))
    mon_u (.*);

//--- testbench/lcdcd_decoder_test.sv
// self-checking testbench for the lcd decoder
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module lcdcd_decoder_test import lcdcd_pkg::*; ();
    // ----------------------------------------------------------------
    // stimulus and plumbing
    // ----------------------------------------------------------------
    logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, serial_mode = 1'b0, vf_running = 1'b0;
    logic [3:0] page_addr = 4'h0, disp_page = 4'h0;  // single page is enough here
    logic [7:0] disp_seg = 8'h00;                     // scan column
    lcdcd_req_t host_req;
    wire logic [7:0] rd_data, column, segment_output;
    wire logic rd_valid, seg_reverse, display_on, invert_on, all_on, bias_seventh;
    wire logic rmw_active, reset_busy;
    logic [7:0] q;
    logic       got;
    int n_fail = 0, num_checks = 0, cyc = 0;
    lcdcd_decoder dut_u (.*);
    lcdcd_host    host_u (.*);
    always #2.5 core_clk = ~core_clk;
    // a hang counts as a mismatch
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] d); host_u.xfer(1'b0, 1'b0, d, q, got); endtask
    task automatic wr(input logic [7:0] d); host_u.xfer(1'b1, 1'b0, d, q, got); endtask
    task automatic rd(); host_u.xfer(1'b1, 1'b1, 8'h00, q, got); endtask
    task automatic sts(); host_u.xfer(1'b0, 1'b1, 8'h00, q, got); endtask
    task automatic seg_chk(input logic [7:0] e);
        @(posedge core_clk);
        #1;
        `CHK("seg", e, segment_output)
    endtask
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        `CHK("reset", {1'b1, 8'h00, 6'h00}, {reset_busy, column, seg_reverse, display_on,
            bias_seventh, rmw_active, all_on, invert_on})
        sts(); `CHK("busy sts", 8'h70, q)
        repeat (6) @(posedge core_clk);
        sts(); `CHK("idle sts", 8'h60, q)
        cmd(8'hAF); cmd(8'hA1); sts(); `CHK("on rev sts", 8'h00, q)
        cmd(8'hA0); sts(); `CHK("fwd sts", 8'h40, q)
        $display("test status done");
        host_u.set_col(8'h23); `CHK("col", 8'h23, column)
        host_u.set_col(8'h81); wr(8'h11); wr(8'h22); wr(8'h33);
        `CHK("col sat", 8'h83, column)
        $display("test write done");
        host_u.set_col(8'h81); rd(); `CHK("dummy", 1'b1, got)
        rd(); `CHK("rd1", 8'h11, q)
        rd(); `CHK("rd2", 8'h22, q)
        $display("test read done");
        host_u.set_col(8'h81); cmd(8'hE0); rd(); rd();
        `CHK("rmw rd", 8'h11, q)
        `CHK("rmw col", 8'h81, column)
        wr(8'h44); `CHK("rmw wr", 8'h82, column)
        cmd(8'hEE); `CHK("rmw end", {1'b0, 8'h81}, {rmw_active, column})
        $display("test rmw done");
        @(posedge core_clk) serial_mode <= 1'b1;
        rd(); `CHK("ser rd", 1'b0, got)
        wr(8'h55); `CHK("ser wr", 8'h82, column)
        @(posedge core_clk) serial_mode <= 1'b0;
        $display("test serial done");
        host_u.set_col(8'h05); wr(8'h5A);
        @(posedge core_clk) disp_seg <= 8'h05;
        seg_chk(8'h5A);
        cmd(8'hA7); seg_chk(8'hA5);
        cmd(8'hA5); seg_chk(8'hFF);
        cmd(8'hA4); cmd(8'hA6); seg_chk(8'h5A);
        cmd(8'hA1);
        @(posedge core_clk) disp_seg <= 8'h7E;
        seg_chk(8'h5A);
        $display("test display done");
        // applied bias trails the requested one by an edge, and only with the follower up
        cmd(8'hA3);
        @(posedge core_clk);
        #1;
        `CHK("bias held", 1'b0, bias_seventh)
        @(posedge core_clk) vf_running <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHK("bias7", 1'b1, bias_seventh)
        cmd(8'hA2);
        @(posedge core_clk);
        #1;
        `CHK("bias9", 1'b0, bias_seventh)
        $display("test bias done");
        end_of_test();
    end
endmodule

//--- testbench/lcdcd_host.sv
// host processor model for the lcd decoder bus
`timescale 1ns/1ps
module lcdcd_host
    import lcdcd_pkg::*;
(
    input  wire logic       core_clk,  // block clock
    output lcdcd_req_t      host_req,  // bus transfer to the decoder
    input  wire logic [7:0] rd_data,   // answer byte
    input  wire logic       rd_valid   // answer strobe
);
    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    initial host_req = '0;
    // strobe for one edge; a released data bus shows the inverse byte so stale data never matches
    task automatic xfer(input logic rs, input logic rd, input logic [7:0] d,
                        output logic [7:0] q, output logic got);
        @(posedge core_clk);
        host_req <= '{valid: 1'b1, reg_select: rs, read: rd, data: d};
        @(posedge core_clk);
        host_req.valid <= 1'b0;
        host_req.data  <= ~d;
        #1;
        q   = rd_data;
        got = rd_valid;
    endtask
    // column set as a pair, never issued while rmw is active
    task automatic set_col(input logic [7:0] c);
        logic [7:0] q;
        logic       got;
        xfer(1'b0, 1'b0, {4'h1, c[7:4]}, q, got);
        xfer(1'b0, 1'b0, {4'h0, c[3:0]}, q, got);
    endtask
endmodule
